// file: core/emc_ctrl.sv
/*
 External memory bus controller with its request FIFO.
 Assumes requests and configuration come from logic on core_clk, and that
 the external read data settles within the strobe window it times itself.
*/
`include "emc_defs.svh"

// ----------------------------------------------------------------------
// Request FIFO
// ----------------------------------------------------------------------
module emc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `EMC_FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("emc_fifo depth must be a power of two of at least two");
   end

   logic [WIDTH-1:0] mem [DEPTH];         // Storage, no reset needed
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign next_count = (push && !pop) ? count + 1'b1 :
                       (!push && pop) ? count - 1'b1 : count;
   assign out_data = mem[rd_ptr];

   // Flags are registered so both ready and valid leave from flip-flops
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else if (clk_en) begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= next_count;
         in_ready <= next_count != (AW + 1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

   // Entry write
   always_ff @(posedge core_clk) begin
      if (clk_en && push) mem[wr_ptr] <= in_data;
   end
endmodule // emc_fifo

// ----------------------------------------------------------------------
// Controller
// ----------------------------------------------------------------------
module emc_ctrl (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Processor requests and answers
   input wire logic req_valid,
   input wire emc_pkg::emc_req_t req,
   output logic req_ready,
   output emc_pkg::emc_rsp_t rsp,
   output logic busy,
   // Configuration
   input wire logic cfg_wr,
   input wire logic [`EMC_IDX_W-1:0] cfg_idx,
   input wire emc_pkg::emc_cs_cfg_t cfg_data,
   input wire logic ctl_wr,
   input wire logic ctl_early,
   input wire logic remap_command_bit,
   // External bus
   output logic [`EMC_ADDR_W-1:1] ext_addr,
   output logic lowest_address_bit,
   output logic [`EMC_NCS-1:0] ext_cs_n,
   output logic read_strobe_n,
   output logic low_byte_write_strobe_n,
   output logic high_byte_write_strobe_n,
   output logic [`EMC_DATA_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic [`EMC_DATA_W-1:0] data_in
);
   localparam int RW = $bits(emc_pkg::emc_req_t);

   // ----------------------------------------------------------------------
   // Configuration state
   // ----------------------------------------------------------------------
   emc_pkg::emc_cs_cfg_t cfg_q [`EMC_NCS];  // Written values
   logic [`EMC_BASE_W-1:0] boot_base;       // Base the boot window decodes with
   logic early_q;                           // Early read protocol
   wire [`EMC_BASE_W-1:0] cfg0_base = cfg_q[0].base;

   // Boot select written fields act at once; only its base waits for remap
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < `EMC_NCS; i++) cfg_q[i] <= '0;
         cfg_q[0].cs_enable <= `EMC_BOOT_ENABLE;
         cfg_q[0].base <= `EMC_BOOT_BASE;
         cfg_q[0].page_code <= `EMC_BOOT_PAGE;
         cfg_q[0].wait_insert_enable <= `EMC_BOOT_WAIT_EN;
         cfg_q[0].wait_count <= `EMC_BOOT_WAIT_CNT;
         cfg_q[0].bus_width_sel <= `EMC_BOOT_DBW;
         cfg_q[0].byte_access_type <= `EMC_BOOT_BAT;
         cfg_q[0].float_cycles <= `EMC_BOOT_TDF;
         boot_base <= `EMC_BOOT_BASE;
         early_q <= `EMC_EARLY_RST;
      end else if (clk_en) begin
         if (cfg_wr && cfg_idx < `EMC_IDX_W'(`EMC_NCS)) cfg_q[cfg_idx] <= cfg_data;
         if (remap_command_bit) boot_base <= cfg0_base;
         if (ctl_wr) early_q <= ctl_early;
      end
   end

   // ----------------------------------------------------------------------
   // Request queue
   // ----------------------------------------------------------------------
   logic head_valid;
   logic [RW-1:0] head_bits;
   logic pop;
   emc_pkg::emc_req_t head;
   assign head = emc_pkg::emc_req_t'(head_bits);

   // Back-pressure: the queue only drains as accesses start or abort
   emc_fifo #(.WIDTH(RW), .DEPTH(`EMC_FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(req),
      .out_valid(head_valid),
      .out_ready(pop),
      .out_data(head_bits)
   );

   // ----------------------------------------------------------------------
   // Window decode
   // ----------------------------------------------------------------------
   logic [`EMC_NCS-1:0] hit_vec;
   logic [`EMC_NCS-1:0] sel_oh;
   logic [`EMC_IDX_W-1:0] sel_idx;
   wire hit_any = |hit_vec;

   for (genvar gi = 0; gi < `EMC_NCS; gi++) begin : g_dec
      wire [`EMC_BASE_W-1:0] mask = `EMC_BASE_W'hfff << cfg_q[gi].page_code;
      wire [`EMC_BASE_W-1:0] base = (gi == 0) ? boot_base : cfg_q[gi].base;
      wire [`EMC_BASE_W-1:0] tag = head.addr[31:`EMC_BASE_LSB];
      assign hit_vec[gi] = cfg_q[gi].cs_enable & ((tag & mask) == (base & mask));
   end

   // Lowest matching window wins so only one select can ever assert
   assign sel_oh = hit_vec & ~(hit_vec - 1'b1);

   always_comb begin
      sel_idx = '0;
      for (int i = 0; i < `EMC_NCS; i++) begin
         if (sel_oh[i]) sel_idx = `EMC_IDX_W'(i);
      end
   end

   emc_pkg::emc_cs_cfg_t sel_cfg;
   assign sel_cfg = cfg_q[sel_idx];
   // Boot select cannot be switched to 8-bit
   wire sel_dbw8 = (sel_idx != '0) && (sel_cfg.bus_width_sel == `EMC_DBW_8);
   wire [3:0] sel_waits = sel_cfg.wait_insert_enable ?
                          {1'b0, sel_cfg.wait_count} + 4'h1 : 4'h0;

   // ----------------------------------------------------------------------
   // Access history and float count
   // ----------------------------------------------------------------------
   logic prev_valid;
   logic [`EMC_IDX_W-1:0] prev_idx;
   logic prev_write;
   logic [2:0] prev_tdf;
   logic [2:0] float_n;
   wire same_cs = prev_idx == sel_idx;
   wire [2:0] tdf_min1 = (prev_tdf == 3'h0) ? 3'h1 : prev_tdf;
   wire [2:0] same_float = prev_write ? ((!head.write && early_q) ? 3'h1 : 3'h0) :
                           (head.write ? prev_tdf : 3'h0);
   // Write after read keeps the bus free while the memory lets go of it
   assign float_n = !prev_valid ? 3'h0 : same_cs ? same_float :
                    (prev_write ? 3'h1 : tdf_min1);

   // ----------------------------------------------------------------------
   // Current access
   // ----------------------------------------------------------------------
   emc_pkg::emc_state_t state;
   emc_pkg::emc_state_t next_state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [`EMC_IDX_W-1:0] cur_idx;
   logic [`EMC_ADDR_W-1:0] cur_addr;
   logic [`EMC_DATA_W-1:0] cur_wdata;
   logic [`EMC_DATA_W-1:0] rd_buf;
   logic [3:0] cur_waits;
   logic [2:0] cur_tdf;
   logic cur_write;
   logic cur_half;
   logic cur_bat;
   logic cur_dbw8;
   logic beat;
   logic launch;
   logic finish;
   logic abort;
   logic beat_next;

   // A half-word to an 8-bit device needs a second byte cycle
   wire more_beat = cur_dbw8 & cur_half & ~beat;
   // Back-to-back early reads on one select keep the strobe down
   wire cont = early_q & ~cur_write & head_valid & hit_any & ~head.write &
               (sel_idx == cur_idx);
   wire strobe_end = (state == emc_pkg::ST_STROBE) && (cnt == 4'h0);

   // Sequencer: setup clock, strobe for one plus the wait clocks, floats between
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      launch = 1'b0;
      finish = 1'b0;
      abort = 1'b0;
      beat_next = 1'b0;
      case (state)
         emc_pkg::ST_IDLE: begin
            if (head_valid && !hit_any) begin
               abort = 1'b1;
            end else if (head_valid && float_n != 3'h0) begin
               next_state = emc_pkg::ST_FLOAT;
               next_cnt = {1'b0, float_n} - 4'h1;
            end else if (head_valid) begin
               launch = 1'b1;
            end
         end
         emc_pkg::ST_FLOAT: begin
            if (cnt != 4'h0) next_cnt = cnt - 4'h1;
            else if (head_valid && hit_any) launch = 1'b1;
            else next_state = emc_pkg::ST_IDLE;
         end
         emc_pkg::ST_SETUP: begin
            next_state = emc_pkg::ST_STROBE;
            next_cnt = cur_waits;
         end
         emc_pkg::ST_STROBE: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else if (more_beat) begin
               next_state = emc_pkg::ST_SETUP;
               beat_next = 1'b1;
            end else begin
               finish = 1'b1;
               next_state = emc_pkg::ST_IDLE;
               launch = cont;
            end
         end
         default: next_state = emc_pkg::ST_IDLE;
      endcase
      if (launch) next_state = emc_pkg::ST_SETUP;
   end
   assign pop = launch | abort;

   // Values the pins will show next, taken from the head on a launch
   wire [`EMC_ADDR_W-1:0] head_off = {head.addr[`EMC_ADDR_W-1:1],
                                     head.addr[0] & ~(head.half & sel_dbw8)};
   wire [`EMC_ADDR_W-1:0] nx_addr = launch ? head_off :
                                    beat_next ? {cur_addr[`EMC_ADDR_W-1:1], 1'b1} : cur_addr;
   wire [`EMC_IDX_W-1:0] nx_idx = launch ? sel_idx : cur_idx;
   wire [`EMC_DATA_W-1:0] nx_wdata = launch ? head.wdata : cur_wdata;
   wire nx_write = launch ? head.write : cur_write;
   wire nx_half = launch ? head.half : cur_half;
   wire nx_bat = launch ? sel_cfg.byte_access_type : cur_bat;
   wire nx_dbw8 = launch ? sel_dbw8 : cur_dbw8;

   // Read data: an 8-bit device returns its byte on bits 7:0, placed in the lane of its address
   wire [`EMC_DATA_W-1:0] cap_data = !cur_dbw8 ? data_in :
      cur_addr[0] ? {data_in[7:0], rd_buf[7:0]} : {rd_buf[15:8], data_in[7:0]};

   // Sequencer and access registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= emc_pkg::ST_IDLE;
         cnt <= 4'h0;
         {cur_idx, cur_addr, cur_wdata, cur_waits, cur_tdf} <= '0;
         {cur_write, cur_half, cur_bat, cur_dbw8, beat} <= '0;
         rd_buf <= '0;
         {prev_valid, prev_idx, prev_write, prev_tdf} <= '0;
      end else if (clk_en) begin
         state <= next_state;
         cnt <= next_cnt;
         if (strobe_end) rd_buf <= cap_data;
         if (launch) begin
            {cur_idx, cur_addr, cur_wdata} <= {nx_idx, nx_addr, nx_wdata};
            {cur_write, cur_half, cur_bat, cur_dbw8} <= {nx_write, nx_half, nx_bat, nx_dbw8};
            cur_waits <= sel_waits;
            cur_tdf <= sel_cfg.float_cycles;
            beat <= 1'b0;
         end else if (beat_next) begin
            cur_addr <= nx_addr;
            beat <= 1'b1;
         end
         if (finish) {prev_valid, prev_idx, prev_write, prev_tdf} <=
            {1'b1, cur_idx, cur_write, cur_tdf};
      end
   end

   // ----------------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------------
   wire in_acc = (next_state == emc_pkg::ST_SETUP) || (next_state == emc_pkg::ST_STROBE);
   wire strobe_ph = next_state == emc_pkg::ST_STROBE;
   wire lo_en = nx_half | ~nx_addr[0];
   wire hi_en = nx_half | nx_addr[0];
   wire wr_ph = strobe_ph & nx_write;
   wire next_rd_n = ~(in_acc & ~nx_write & (strobe_ph | early_q));
   // Byte select and single 8-bit use it as the one write strobe
   wire next_w0_n = ~(wr_ph & (nx_bat | nx_dbw8 | lo_en));
   wire next_w1_n = nx_bat ? ~(in_acc & hi_en) :
                    nx_dbw8 ? 1'b1 : ~(wr_ph & hi_en);
   wire next_a0 = nx_bat ? ~(in_acc & lo_en) : nx_addr[0];
   wire [`EMC_NCS-1:0] next_cs_n = in_acc ? ~(`EMC_NCS'(1) << nx_idx) : '1;
   wire [`EMC_DATA_W-1:0] next_dout = !nx_dbw8 ? nx_wdata :
      {8'h00, nx_addr[0] ? nx_wdata[15:8] : nx_wdata[7:0]};

   // Pins and answers leave from flip-flops
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_addr <= '0;
         lowest_address_bit <= 1'b1;
         ext_cs_n <= '1;
         read_strobe_n <= 1'b1;
         low_byte_write_strobe_n <= 1'b1;
         high_byte_write_strobe_n <= 1'b1;
         data_out <= '0;
         data_oe_n <= 1'b1;
         rsp <= '0;
         busy <= 1'b0;
      end else if (clk_en) begin
         ext_addr <= nx_addr[`EMC_ADDR_W-1:1];
         lowest_address_bit <= next_a0;
         ext_cs_n <= next_cs_n;
         read_strobe_n <= next_rd_n;
         low_byte_write_strobe_n <= next_w0_n;
         high_byte_write_strobe_n <= next_w1_n;
         data_out <= next_dout;
         data_oe_n <= ~(in_acc & nx_write);
         rsp.valid <= finish | abort;
         rsp.rdata <= finish ? cap_data : '0;
         rsp.prefetch_abort <= abort & head.fetch;
         rsp.data_abort <= abort & ~head.fetch;
         busy <= next_state != emc_pkg::ST_IDLE;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   logic [3:0] strb_clks;  // Clocks spent in strobe beyond the first
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) strb_clks <= 4'h0;
      else if (clk_en) strb_clks <= (state == emc_pkg::ST_STROBE) ? strb_clks + 4'h1 : 4'h0;
   end

   a_cs_onehot: assert property ($onehot0(~ext_cs_n))
      else $error("more than one chip select active");
   a_addr_drive: assert property (state == emc_pkg::ST_STROBE |-> ext_addr == cur_addr[21:1])
      else $error("address pins differ from access");
   a_wait_len: assert property (strobe_end && clk_en |-> strb_clks == cur_waits)
      else $error("strobe length differs from wait count");
   // Early mode must already pull the read strobe down in the setup clock
   a_early_read: assert property (state == emc_pkg::ST_SETUP && !cur_write
      && $past(early_q) |-> !read_strobe_n)
      else $error("early read strobe missing");
   a_std_read: assert property ($rose(state == emc_pkg::ST_SETUP) && !cur_write
      && !early_q && !$past(early_q) |-> read_strobe_n && !(&ext_cs_n))
      else $error("standard read strobe in setup half");
   a_remap_base: assert property (clk_en && remap_command_bit |=> boot_base == $past(cfg0_base))
      else $error("remap did not load boot base");
   a_base_held: assert property (!$past(remap_command_bit) |-> $stable(boot_base))
      else $error("boot base changed without remap");
   a_abort_kind: assert property (state == emc_pkg::ST_IDLE && head_valid && !hit_any && clk_en
      |=> rsp.valid && rsp.prefetch_abort == $past(head.fetch)
      && rsp.data_abort != $past(head.fetch))
      else $error("wrong abort answer");
   a_float_enter: assert property (state == emc_pkg::ST_IDLE && head_valid && hit_any
      && float_n != 3'h0 && clk_en |=> state == emc_pkg::ST_FLOAT
      && cnt + 4'h1 == {1'b0, $past(float_n)})
      else $error("float count not loaded");
   a_bsel_write: assert property (state == emc_pkg::ST_STROBE && cur_bat && cur_write
      |-> !low_byte_write_strobe_n)
      else $error("common write strobe missing");
   a_bw8_upper: assert property (!cur_bat && cur_dbw8 && state != emc_pkg::ST_IDLE
      |-> high_byte_write_strobe_n)
      else $error("upper strobe used on 8-bit device");

   c_abort: cover property (rsp.valid && rsp.data_abort);
   c_float: cover property (state == emc_pkg::ST_FLOAT);
   c_cont_read: cover property (strobe_end && cont && clk_en);
   c_two_beats: cover property (beat_next && clk_en);
endmodule // emc_ctrl

// file: core/emc_defs.svh
/*
 Constants of the external memory bus controller: sizes, field positions,
 boot reset values and encodings.
 Assumes it is included by its bare name from the package and the design file.
*/
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define EMC_NCS 6
`define EMC_IDX_W 3
`define EMC_ADDR_W 22
`define EMC_DATA_W 16
`define EMC_FIFO_DEPTH 8
`define EMC_BASE_W 12
`define EMC_BASE_LSB 20

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define EMC_DBW_16 2'b01
`define EMC_DBW_8 2'b10

// ----------------------------------------------------------------------
// Reset values of the boot chip select and the controller
// ----------------------------------------------------------------------
`define EMC_BOOT_ENABLE 1'b1
`define EMC_BOOT_BASE 12'h000
`define EMC_BOOT_PAGE 2'h3
`define EMC_BOOT_WAIT_EN 1'b1
`define EMC_BOOT_WAIT_CNT 3'h7
`define EMC_BOOT_DBW 2'b01
`define EMC_BOOT_BAT 1'b0
`define EMC_BOOT_TDF 3'h0
`define EMC_EARLY_RST 1'b0

`endif

// file: core/emc_pkg.sv
/*
 Types shared by the external memory bus controller.
 Assumes emc_defs.svh is on the include path.
*/
`include "emc_defs.svh"

package emc_pkg;

   // ----------------------------------------------------------------------
   // Chip select configuration word
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic cs_enable;                      // Window takes part in decode
      logic [`EMC_BASE_W-1:0] base;         // Address bits 31:20 of the window
      logic [1:0] page_code;                // Page is 1 MB shifted by this
      logic wait_insert_enable;
      logic [2:0] wait_count;
      logic [1:0] bus_width_sel;
      logic byte_access_type;               // 1 byte select, 0 byte write
      logic [2:0] float_cycles;
   } emc_cs_cfg_t;

   // ----------------------------------------------------------------------
   // Processor request and answer
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [`EMC_DATA_W-1:0] wdata;        // Bytes sit in their address lane
      logic write;
      logic half;                           // Half-word, else byte
      logic fetch;                          // Instruction fetch
   } emc_req_t;

   typedef struct packed {
      logic valid;
      logic [`EMC_DATA_W-1:0] rdata;
      logic prefetch_abort;
      logic data_abort;
   } emc_rsp_t;

   // ----------------------------------------------------------------------
   // Access sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FLOAT = 4'b0010,
      ST_SETUP = 4'b0100,
      ST_STROBE = 4'b1000
   } emc_state_t;

endpackage

// file: verif/emc_mem_model.sv
/*
 Memory model on the far side: a 16-bit device on select 0, an 8-bit one on select 1,
 a 16-bit byte-select device on select 2.
 Assumes the pin use of emc_ctrl, and that writes only land while it drives the bus.
*/
module emc_mem_model (
   // Clock and bus pins
   input wire logic core_clk,
   input wire logic [21:1] ext_addr,
   input wire logic lowest_address_bit,
   input wire logic [5:0] ext_cs_n,
   input wire logic read_strobe_n,
   input wire logic low_byte_write_strobe_n,
   input wire logic high_byte_write_strobe_n,
   input wire logic [15:0] data_out,
   input wire logic data_oe_n,
   output logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem0 [128]; // Small devices, so contents repeat in a page
   logic [7:0] mem1 [256];
   logic [15:0] mem2 [128];
   logic [15:0] last = 16'h0000; // Undriven lines show the inverse of this
   wire [7:0] ba = {ext_addr[7:1], lowest_address_bit};
   wire [6:0] wa = ext_addr[7:1];
   // A strobe without the controller driving the bus must not write
   wire lo_w = !data_oe_n && !low_byte_write_strobe_n;
   wire hi_w = !data_oe_n && !high_byte_write_strobe_n;
   initial foreach (mem0[i]) mem0[i] = 16'h0000;
   // Drive only while selected and strobed, else a changing pattern
   always_comb begin
      data_in = ~last;
      if (!read_strobe_n && !ext_cs_n[0]) data_in = mem0[ext_addr[7:1]];
      else if (!read_strobe_n && !ext_cs_n[1]) data_in[7:0] = mem1[ba];
      else if (!read_strobe_n && !ext_cs_n[2]) data_in = mem2[wa];
   end
   // Byte strobes write their own lane on selects 0 and 1
   always @(posedge core_clk) begin
      last <= data_in;
      if (!ext_cs_n[0] && lo_w) mem0[wa][7:0] <= data_out[7:0];
      if (!ext_cs_n[0] && hi_w) mem0[wa][15:8] <= data_out[15:8];
      if (!ext_cs_n[1] && lo_w) mem1[ba] <= data_out[7:0];
      // Byte select: common write strobe, lane selects on the shared pins
      if (!ext_cs_n[2] && lo_w && !lowest_address_bit) mem2[wa][7:0] <= data_out[7:0];
      if (!ext_cs_n[2] && lo_w && hi_w) mem2[wa][15:8] <= data_out[15:8];
   end
endmodule // emc_mem_model

// file: verif/testbench.sv
/*
 Self-checking bench of emc_ctrl with a memory model.
 Assumes the package and emc_ctrl are compiled first.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, sys_rst = 1, clk_en = 1, req_valid = 0, req_ready, busy;
   logic cfg_wr = 0, ctl_wr = 0, ctl_early = 0, remap_command_bit = 0;
   logic [2:0] cfg_idx = 3'h0;
   emc_pkg::emc_req_t req = '0;
   emc_pkg::emc_rsp_t rsp;
   emc_pkg::emc_cs_cfg_t cfg_data = '0;
   logic [21:1] ext_addr;
   logic lowest_address_bit, read_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n;
   logic data_oe_n;
   logic [5:0] ext_cs_n;
   logic [15:0] data_out, data_in, d;
   logic [31:0] seed = 32'd11, a;
   int n_fail = 0, checked = 0, rd_lo = 0, rd_len = 0, idle_n = 0;
   emc_ctrl u_emc_ctrl (.core_clk, .sys_rst, .clk_en, .req_valid, .req, .req_ready, .rsp,
      .busy, .cfg_wr, .cfg_idx, .cfg_data, .ctl_wr, .ctl_early, .remap_command_bit, .ext_addr,
      .lowest_address_bit, .ext_cs_n, .read_strobe_n, .low_byte_write_strobe_n,
      .high_byte_write_strobe_n, .data_out, .data_oe_n, .data_in);
   emc_mem_model u_emc_mem_model (.core_clk, .ext_addr, .lowest_address_bit, .ext_cs_n,
      .read_strobe_n, .low_byte_write_strobe_n, .high_byte_write_strobe_n, .data_out,
      .data_oe_n, .data_in);
   always #50 core_clk = ~core_clk;
   // Length of the last read strobe, in clocks
   always @(negedge core_clk) begin
      if (read_strobe_n === 1'b0) rd_lo <= rd_lo + 1;
      else if (rd_lo != 0) begin
         rd_len <= rd_lo;
         rd_lo <= 0;
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Byte lane of an address, as the answer carries it
   function automatic logic [15:0] lane(input logic [31:0] ad, input logic [7:0] b);
      return ad[0] ? {b, 8'h00} : {8'h00, b};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One request, held until taken, then its answer compared
   task automatic acc(input logic [31:0] ad, input logic w, h, f, input logic [15:0] wd,
         input logic [15:0] exp, mask, input logic [1:0] ab);
      int i;
      req = '{ad, wd, w, h, f};
      req_valid = 1;
      for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge core_clk);
      @(negedge core_clk);
      req_valid = 0;
      for (i = 0; i < 200 && rsp.valid !== 1'b1; i++) @(negedge core_clk);
      check(rsp.valid, 1);
      check(rsp.rdata & mask, exp);
      check({rsp.prefetch_abort, rsp.data_abort}, ab);
      @(negedge core_clk);
   endtask
   task automatic cfg(input logic [2:0] i, input emc_pkg::emc_cs_cfg_t c);
      cfg_idx = i;
      cfg_data = c;
      cfg_wr = 1;
      @(negedge core_clk);
      cfg_wr = 0;
   endtask
   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (20) @(negedge core_clk);
      sys_rst = 0;
      for (int k = 0; k < 3; k++) begin
         a = rnd() & 32'h000000fe;
         d = 16'(rnd());
         acc(a, 1, 1, 0, d, 0, 0, 0);
         acc(a, 0, 1, 0, 0, d, 16'hffff, 0);
         check(rd_len, 9);
      end
      acc(32'h80, 1, 1, 0, 16'h1234, 0, 0, 0);
      acc(32'h81, 1, 0, 0, 16'hab00, 0, 0, 0);
      acc(32'h80, 0, 1, 0, 0, 16'hab34, 16'hffff, 0);
      cfg(0, '{1'b1, 12'h002, 2'h0, 1'b1, 3'h2, 2'b01, 1'b0, 3'h0});
      acc(32'h80, 0, 1, 0, 0, 16'hab34, 16'hffff, 0);
      check(rd_len, 4);
      acc(32'h00200080, 0, 1, 0, 0, 0, 16'hffff, 2'b01);
      acc(32'h00400000, 0, 1, 1, 0, 0, 16'hffff, 2'b10);
      remap_command_bit = 1;
      @(negedge core_clk);
      remap_command_bit = 0;
      acc(32'h00200080, 0, 1, 0, 0, 16'hab34, 16'hffff, 0);
      acc(32'h00000080, 0, 1, 0, 0, 0, 16'hffff, 2'b01);
      cfg(1, '{1'b1, 12'h001, 2'h0, 1'b0, 3'h0, 2'b10, 1'b0, 3'h0});
      acc(32'h00100005, 1, 0, 0, 16'h5a00, 0, 0, 0);
      acc(32'h00100105, 0, 0, 0, 0, lane(32'h5, 8'h5a), 16'hff00, 0);
      d = 16'(rnd());
      acc(32'h00100010, 1, 1, 0, d, 0, 0, 0);
      acc(32'h00100010, 0, 1, 0, 0, d, 16'hffff, 0);
      cfg(2, '{1'b1, 12'h003, 2'h0, 1'b0, 3'h0, 2'b01, 1'b1, 3'h0});
      acc(32'h00300010, 1, 1, 0, d, 0, 0, 0);
      acc(32'h00300011, 1, 0, 0, 16'hcd00, 0, 0, 0);
      acc(32'h00300010, 0, 1, 0, 0, {8'hcd, d[7:0]}, 16'hffff, 0);
      req = '{32'h00200080, 16'h0000, 1'b0, 1'b1, 1'b0};
      req_valid = 1;
      repeat (12) @(negedge core_clk);
      check(req_ready, 0);
      req_valid = 0;
      // Busy drops for a clock between queued reads, so wait for a settled idle
      for (int i = 0; i < 400 && idle_n < 4; i++) begin
         @(negedge core_clk);
         idle_n = (busy === 1'b0) ? idle_n + 1 : 0;
      end
      check({req_ready, busy, ext_cs_n}, {2'b10, 6'h3f});
      // Early read: two queued reads keep the strobe down across both
      ctl_early = 1;
      ctl_wr = 1;
      @(negedge core_clk);
      ctl_wr = 0;
      req_valid = 1;
      repeat (2) @(negedge core_clk);
      req_valid = 0;
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 200 && rsp.valid !== 1'b1; i++) @(negedge core_clk);
         check(rsp.valid, 1);
         check(rsp.rdata, 16'hab34);
         @(negedge core_clk);
      end
      check(rd_len, 10);
      // Reset in mid-run: pins idle, boot configuration back
      sys_rst = 1;
      @(negedge core_clk);
      check({ext_cs_n, read_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
         data_oe_n, lowest_address_bit, req_ready, busy}, {6'h3f, 5'h1f, 1'b1, 1'b0});
      sys_rst = 0;
      acc(32'h00000080, 0, 1, 0, 0, 16'hab34, 16'hffff, 0);
      check(rd_len, 9);
      wrap_up();
   end
endmodule // testbench
